// File: rtl/mcr_config_regs.sv
// Metering configuration register bank with reverse-polarity pin and zero-crossing edge logic
//
// Notes on behaviour
// - Noload bit 0 set turns off active power no-load detection; resets zero.
// - Noload bit 1 set turns off reactive power no-load detection; resets zero.
// - Noload bit 2 set turns off apparent power no-load detection; resets zero.
// - Line-cycle bits 0,1 enable active energy accumulation for channels A,B.
// - Line-cycle bits 2,3 enable reactive energy accumulation for channels A,B.
// - Line-cycle bits 4,5 enable apparent energy accumulation for channels A,B.
// - Line-cycle bit 6, set at reset, enables clear-on-read for all registers.
// - Config bits 0,1 switch on integrators of channels A and B.
// - Config bit 2 enables high-pass filter; reads one after reset.
// - Config bit 3 picks power-factor basis: instantaneous or line-cycle energies.
// - Config bit 4 picks pulse output that updates reverse-polarity indication.
// - Config bit 5: reverse pin level or 1 Hz pulses; low otherwise.
// - Config bit 6 clear keeps zero-crossing low-pass filter active; set bypasses.
// - Writing one to config bit 7 starts a software reset.
// - Config bit 8 enables register checksum; resets cleared.
// - Config bit 11 picks current channel for current zero crossing.
// - Edge field 01 negative, 10 positive, 00/11 both edges raise interrupt.
// - Config bit 15 clear means interface locking active; resets to one.
`include "mcr_consts.svh"

module mcr_config_regs #(
  parameter int REVERSE_POLARITY_PIN_PERIOD_CYC = `MCR_REVERSE_POLARITY_PIN_PERIOD_NS / `MCR_CLK_PERIOD_NS
) (
  input wire logic mclk_in, // Device clock, 100 MHz
  input wire logic rst_in, // Synchronous reset, active high
  input wire logic wr_en_in, // Register write strobe
  input wire logic rd_en_in, // Register read strobe
  input wire logic [`MCR_ADDR_W-1:0] addr_in, // Register address
  input wire logic [15:0] wr_data_in, // Write data, low bits used by narrow registers
  output logic [15:0] rd_data_out, // Read data, one cycle after the strobe
  output logic rd_valid_out, // Read data valid pulse
  input wire logic reverse_polarity_in, // Reverse polarity detected by the energy core
  input wire logic pulse_out_one_in, // First energy pulse output
  input wire logic pulse_out_two_in, // Second energy pulse output
  input wire logic voltage_sign_in, // Voltage channel sign, high when positive
  input wire logic chan_a_sign_in, // Current channel A sign
  input wire logic chan_b_sign_in, // Current channel B sign
  output mcr_pkg::mcr_ctrl_s ctrl_out, // Control bits to the datapath
  output logic soft_reset_out, // Software reset pulse to the device
  output logic reverse_polarity_pin_out, // Reverse polarity pin
  output logic crossing_irq_out, // Zero-crossing interrupt pulse
  output logic current_crossing_out // Sign of the selected current channel
);
  import mcr_pkg::*;

  localparam logic [31:0] REVERSE_POLARITY_PIN_HALF = 32'(REVERSE_POLARITY_PIN_PERIOD_CYC / 2);
  localparam logic [31:0] REVERSE_POLARITY_PIN_LAST = 32'(REVERSE_POLARITY_PIN_PERIOD_CYC - 1);

  mcr_state_s st;
  mcr_state_s next_st;

  logic pulse_sel;
  logic pulse_rise;
  logic pos_edge;
  logic neg_edge;
  logic [1:0] edge_sel;

  // ==========================================================================
  // Next-state logic
  always_comb begin
    next_st = st;
    next_st.rd_valid = 1'b0;
    next_st.soft_reset = 1'b0;
    // Register writes, reserved bits dropped
    if (wr_en_in) begin
      case (addr_in)
        `MCR_OFS_NOLOAD: begin
          next_st.noload_disable = wr_data_in[7:0] & `MCR_MASK_NOLOAD;
        end
        `MCR_OFS_LINECYC: begin
          next_st.line_cycle_mode = wr_data_in[7:0] & `MCR_MASK_LINECYC;
        end
        `MCR_OFS_CONFIG: begin
          next_st.main_config = wr_data_in & `MCR_MASK_CONFIG;
          next_st.main_config[`MCR_CF_SOFT_RESET] = 1'b0;
          next_st.soft_reset = wr_data_in[`MCR_CF_SOFT_RESET];
        end
        default: begin
        end
      endcase
    end
    // Register reads; unmapped addresses return zero
    if (rd_en_in) begin
      next_st.rd_valid = 1'b1;
      case (addr_in)
        `MCR_OFS_NOLOAD: next_st.rd_data = {8'h00, st.noload_disable};
        `MCR_OFS_LINECYC: next_st.rd_data = {8'h00, st.line_cycle_mode};
        `MCR_OFS_CONFIG: next_st.rd_data = st.main_config;
        default: next_st.rd_data = 16'h0000;
      endcase
    end
    // Reverse polarity sampled on rising edge of the chosen pulse output
    next_st.pulse_one_d = pulse_out_one_in;
    next_st.pulse_two_d = pulse_out_two_in;
    if (pulse_rise) begin
      next_st.reverse_held = reverse_polarity_in;
    end
    if (st.reverse_held && st.reverse_polarity_pin_cnt != REVERSE_POLARITY_PIN_LAST) begin
      next_st.reverse_polarity_pin_cnt = st.reverse_polarity_pin_cnt + 32'h1;
    end else begin
      next_st.reverse_polarity_pin_cnt = 32'h0;
    end
    if (!st.reverse_held) begin
      next_st.reverse_polarity_pin = 1'b0;
    end else if (st.main_config[`MCR_CF_REVERSE_POLARITY_PIN_STYLE]) begin
      next_st.reverse_polarity_pin = (st.reverse_polarity_pin_cnt < REVERSE_POLARITY_PIN_HALF);
    end else begin
      next_st.reverse_polarity_pin = 1'b1;
    end
    // Zero-crossing interrupt edge selection
    next_st.volt_sign_d = voltage_sign_in;
    case (edge_sel)
      `MCR_EDGE_NEG: next_st.crossing_irq = neg_edge;
      `MCR_EDGE_POS: next_st.crossing_irq = pos_edge;
      default: next_st.crossing_irq = pos_edge | neg_edge;
    endcase
    next_st.current_crossing = st.main_config[`MCR_CF_ZXI_SRC] ? chan_b_sign_in : chan_a_sign_in;
    // Software reset returns every register to its default next cycle
    if (st.soft_reset) begin
      next_st.noload_disable = `MCR_RST_NOLOAD;
      next_st.line_cycle_mode = `MCR_RST_LINECYC;
      next_st.main_config = `MCR_RST_CONFIG;
      next_st.reverse_held = 1'b0;
      next_st.reverse_polarity_pin = 1'b0;
      next_st.reverse_polarity_pin_cnt = 32'h0;
      next_st.crossing_irq = 1'b0;
    end
  end

  assign pulse_sel = st.main_config[`MCR_CF_REVERSE_POLARITY_PIN_SRC] ? pulse_out_two_in : pulse_out_one_in;
  assign pulse_rise = pulse_sel & ~(st.main_config[`MCR_CF_REVERSE_POLARITY_PIN_SRC] ? st.pulse_two_d : st.pulse_one_d);
  assign pos_edge = voltage_sign_in & ~st.volt_sign_d;
  assign neg_edge = ~voltage_sign_in & st.volt_sign_d;
  assign edge_sel = st.main_config[`MCR_CF_EDGE_HI:`MCR_CF_EDGE_LO];

  // ==========================================================================
  // State register
  always_ff @(posedge mclk_in) begin
    if (rst_in) begin
      st <= '0;
      st.line_cycle_mode <= `MCR_RST_LINECYC;
      st.main_config <= `MCR_RST_CONFIG;
    end else begin
      st <= next_st;
    end
  end

  // ==========================================================================
  // Outputs
  always_comb begin
    ctrl_out.active_noload_off = st.noload_disable[`MCR_NL_ACTIVE];
    ctrl_out.reactive_noload_off = st.noload_disable[`MCR_NL_REACTIVE];
    ctrl_out.apparent_noload_off = st.noload_disable[`MCR_NL_APPARENT];
    ctrl_out.chan_a_active_linecycle_en = st.line_cycle_mode[`MCR_LC_A_ACTIVE];
    ctrl_out.chan_b_active_linecycle_en = st.line_cycle_mode[`MCR_LC_B_ACTIVE];
    ctrl_out.chan_a_reactive_linecycle_en = st.line_cycle_mode[`MCR_LC_A_REACTIVE];
    ctrl_out.chan_b_reactive_linecycle_en = st.line_cycle_mode[`MCR_LC_B_REACTIVE];
    ctrl_out.chan_a_apparent_linecycle_en = st.line_cycle_mode[`MCR_LC_A_APPARENT];
    ctrl_out.chan_b_apparent_linecycle_en = st.line_cycle_mode[`MCR_LC_B_APPARENT];
    ctrl_out.clear_on_read_en = st.line_cycle_mode[`MCR_LC_CLR_ON_READ];
    ctrl_out.chan_a_integrator_on = st.main_config[`MCR_CF_INT_A];
    ctrl_out.chan_b_integrator_on = st.main_config[`MCR_CF_INT_B];
    ctrl_out.highpass_on = st.main_config[`MCR_CF_HPF];
    ctrl_out.powerfactor_basis = st.main_config[`MCR_CF_PF_BASIS];
    ctrl_out.crossing_filter_off = st.main_config[`MCR_CF_ZX_FILT_OFF];
    ctrl_out.checksum_on = st.main_config[`MCR_CF_CHECKSUM];
    ctrl_out.interface_lock_on = ~st.main_config[`MCR_CF_LOCK_OFF];
  end

  assign rd_data_out = st.rd_data;
  assign rd_valid_out = st.rd_valid;
  assign soft_reset_out = st.soft_reset;
  assign reverse_polarity_pin_out = st.reverse_polarity_pin;
  assign crossing_irq_out = st.crossing_irq;
  assign current_crossing_out = st.current_crossing;

  // ==========================================================================
  // Checks
  default clocking cb @(posedge mclk_in);
  endclocking
  default disable iff (rst_in);

  sequence cfg_write_s;
    wr_en_in && addr_in == `MCR_OFS_CONFIG && !wr_data_in[`MCR_CF_SOFT_RESET];
  endsequence

  sequence soft_write_s;
    wr_en_in && addr_in == `MCR_OFS_CONFIG && wr_data_in[`MCR_CF_SOFT_RESET];
  endsequence

  sequence soft_done_s;
    soft_reset_out ##1 (st.main_config == `MCR_RST_CONFIG && st.line_cycle_mode == `MCR_RST_LINECYC);
  endsequence

  noload_write_a: assert property (wr_en_in && addr_in == `MCR_OFS_NOLOAD && !soft_reset_out |=>
    {ctrl_out.apparent_noload_off, ctrl_out.reactive_noload_off, ctrl_out.active_noload_off} == $past(wr_data_in[2:0]))
    else $error("noload bits do not follow write");

  linecyc_write_a: assert property (wr_en_in && addr_in == `MCR_OFS_LINECYC && !soft_reset_out |=>
    st.line_cycle_mode == ($past(wr_data_in[7:0]) & `MCR_MASK_LINECYC) &&
    ctrl_out.clear_on_read_en == $past(wr_data_in[6]))
    else $error("line cycle bits do not follow write");

  config_write_a: assert property (cfg_write_s and !soft_reset_out |=>
    st.main_config == ($past(wr_data_in) & `MCR_MASK_CONFIG) &&
    ctrl_out.interface_lock_on == !$past(wr_data_in[`MCR_CF_LOCK_OFF]))
    else $error("config bits do not follow write");

  reserved_zero_a: assert property (rd_valid_out && $past(addr_in) == `MCR_OFS_CONFIG |->
    rd_data_out[14] == 1'b0 && rd_data_out[10:9] == 2'h0)
    else $error("reserved config bits read nonzero");

  soft_reset_a: assert property (soft_write_s |=> soft_done_s)
    else $error("software reset did not restore defaults");

  reverse_polarity_pin_low_a: assert property (!st.reverse_held |=> !reverse_polarity_pin_out)
    else $error("reverse pin high without reverse polarity");

  reverse_polarity_pin_level_a: assert property (st.reverse_held && !st.main_config[`MCR_CF_REVERSE_POLARITY_PIN_STYLE] && !soft_reset_out
    |=> reverse_polarity_pin_out)
    else $error("reverse pin not high in level style");

  reverse_polarity_pin_update_a: assert property (pulse_rise && !soft_reset_out |=> st.reverse_held == $past(reverse_polarity_in))
    else $error("reverse polarity not sampled on pulse edge");

  edge_neg_a: assert property (edge_sel == `MCR_EDGE_NEG && pos_edge && !soft_reset_out |=> !crossing_irq_out)
    else $error("positive crossing raised irq in negative mode");

  edge_both_a: assert property ((edge_sel == 2'h0 || edge_sel == 2'h3) && (pos_edge || neg_edge) && !soft_reset_out
    |=> crossing_irq_out)
    else $error("crossing missed in both-edge mode");

  zxi_src_a: assert property (##1 current_crossing_out ==
    ($past(st.main_config[`MCR_CF_ZXI_SRC]) ? $past(chan_b_sign_in) : $past(chan_a_sign_in)))
    else $error("current crossing taken from wrong channel");

  reset_vals_a: assert property ($fell(rst_in) |-> ctrl_out.highpass_on && ctrl_out.clear_on_read_en &&
    !ctrl_out.interface_lock_on && !ctrl_out.checksum_on)
    else $error("wrong values after reset");

  noload_hold_a: assert property (!(wr_en_in && addr_in == `MCR_OFS_NOLOAD) && !soft_reset_out
    |=> $stable(st.noload_disable))
    else $error("noload register changed without a write");

  linecyc_hold_a: assert property (!(wr_en_in && addr_in == `MCR_OFS_LINECYC) && !soft_reset_out
    |=> $stable(st.line_cycle_mode))
    else $error("line cycle register changed without a write");

  config_hold_a: assert property (!(wr_en_in && addr_in == `MCR_OFS_CONFIG) && !soft_reset_out
    |=> $stable(st.main_config))
    else $error("config register changed without a write");

  cfg_reserved_a: assert property (st.main_config[14] == 1'b0 && st.main_config[10:9] == 2'h0)
    else $error("reserved config bits held nonzero");

  soft_reset_req_bit_a: assert property (st.main_config[`MCR_CF_SOFT_RESET] == 1'b0)
    else $error("software reset bit stored");

  noload_unused_a: assert property (st.noload_disable[7:3] == 5'h00)
    else $error("unused noload bits held nonzero");

  linecyc_unused_a: assert property (st.line_cycle_mode[7] == 1'b0)
    else $error("unused line cycle bit held nonzero");

  soft_pulse_a: assert property (soft_reset_out && !(wr_en_in && addr_in == `MCR_OFS_CONFIG &&
    wr_data_in[`MCR_CF_SOFT_RESET]) |=> !soft_reset_out)
    else $error("software reset pulse longer than one cycle");

  soft_only_a: assert property (!(wr_en_in && addr_in == `MCR_OFS_CONFIG && wr_data_in[`MCR_CF_SOFT_RESET])
    |=> !soft_reset_out)
    else $error("software reset without request");

  read_valid_a: assert property (rd_en_in |=> rd_valid_out)
    else $error("read answer missing");

  read_quiet_a: assert property (!rd_en_in |=> !rd_valid_out)
    else $error("read answer without request");

  read_noload_a: assert property (rd_en_in && addr_in == `MCR_OFS_NOLOAD
    |=> rd_data_out == {8'h00, $past(st.noload_disable)})
    else $error("noload read returns wrong data");

  read_linecyc_a: assert property (rd_en_in && addr_in == `MCR_OFS_LINECYC
    |=> rd_data_out == {8'h00, $past(st.line_cycle_mode)})
    else $error("line cycle read returns wrong data");

  read_config_a: assert property (rd_en_in && addr_in == `MCR_OFS_CONFIG
    |=> rd_data_out == $past(st.main_config))
    else $error("config read returns wrong data");

  unmapped_read_a: assert property (rd_en_in && addr_in != `MCR_OFS_NOLOAD && addr_in != `MCR_OFS_LINECYC &&
    addr_in != `MCR_OFS_CONFIG |=> rd_data_out == 16'h0000)
    else $error("unmapped read returns nonzero");

  reverse_pol_pulse_style_hi_a: assert property (st.reverse_held && st.main_config[`MCR_CF_REVERSE_POLARITY_PIN_STYLE] &&
    st.reverse_polarity_pin_cnt < REVERSE_POLARITY_PIN_HALF && !soft_reset_out |=> reverse_polarity_pin_out)
    else $error("reverse pin low in first half of pulse");

  reverse_pol_pulse_style_lo_a: assert property (st.reverse_held && st.main_config[`MCR_CF_REVERSE_POLARITY_PIN_STYLE] &&
    st.reverse_polarity_pin_cnt >= REVERSE_POLARITY_PIN_HALF |=> !reverse_polarity_pin_out)
    else $error("reverse pin high in second half of pulse");

  reverse_polarity_pin_wrap_a: assert property (st.reverse_polarity_pin_cnt <= REVERSE_POLARITY_PIN_LAST)
    else $error("reverse pulse counter past its period");

  reverse_polarity_pin_hold_a: assert property (!pulse_rise && !soft_reset_out |=> $stable(st.reverse_held))
    else $error("reverse polarity taken between pulse edges");

  edge_pos_a: assert property (edge_sel == `MCR_EDGE_POS && neg_edge |=> !crossing_irq_out)
    else $error("negative crossing raised irq in positive mode");

  edge_neg_hit_a: assert property (edge_sel == `MCR_EDGE_NEG && neg_edge && !soft_reset_out
    |=> crossing_irq_out)
    else $error("negative crossing missed");

  edge_pos_hit_a: assert property (edge_sel == `MCR_EDGE_POS && pos_edge && !soft_reset_out
    |=> crossing_irq_out)
    else $error("positive crossing missed");

  irq_quiet_a: assert property (!pos_edge && !neg_edge |=> !crossing_irq_out)
    else $error("irq without a crossing");

  ctrl_lock_a: assert property (ctrl_out.interface_lock_on == !st.main_config[`MCR_CF_LOCK_OFF])
    else $error("lock control not inverse of its bit");

  ctrl_filter_a: assert property (ctrl_out.crossing_filter_off == st.main_config[`MCR_CF_ZX_FILT_OFF])
    else $error("crossing filter control wrong");

endmodule : mcr_config_regs

// File: rtl/mcr_consts.svh
// Register map, field positions, reset values and timing periods in ns of the metering configuration registers
`ifndef MCR_CONSTS_SVH
`define MCR_CONSTS_SVH

// ==========================================================================
// Register offsets
`define MCR_ADDR_W 10
`define MCR_OFS_NOLOAD 10'h001
`define MCR_OFS_LINECYC 10'h004
`define MCR_OFS_CONFIG 10'h102

// ==========================================================================
// Reset values and writable masks
`define MCR_RST_NOLOAD 8'h00
`define MCR_RST_LINECYC 8'h40
`define MCR_RST_CONFIG 16'h8004
`define MCR_MASK_NOLOAD 8'h07
`define MCR_MASK_LINECYC 8'h7f
`define MCR_MASK_CONFIG 16'hb97f

// ==========================================================================
// Field positions
`define MCR_NL_ACTIVE 0
`define MCR_NL_REACTIVE 1
`define MCR_NL_APPARENT 2
`define MCR_LC_A_ACTIVE 0
`define MCR_LC_B_ACTIVE 1
`define MCR_LC_A_REACTIVE 2
`define MCR_LC_B_REACTIVE 3
`define MCR_LC_A_APPARENT 4
`define MCR_LC_B_APPARENT 5
`define MCR_LC_CLR_ON_READ 6
`define MCR_CF_INT_A 0
`define MCR_CF_INT_B 1
`define MCR_CF_HPF 2
`define MCR_CF_PF_BASIS 3
`define MCR_CF_REVERSE_POLARITY_PIN_SRC 4
`define MCR_CF_REVERSE_POLARITY_PIN_STYLE 5
`define MCR_CF_ZX_FILT_OFF 6
`define MCR_CF_SOFT_RESET 7
`define MCR_CF_CHECKSUM 8
`define MCR_CF_ZXI_SRC 11
`define MCR_CF_EDGE_LO 12
`define MCR_CF_EDGE_HI 13
`define MCR_CF_LOCK_OFF 15

// ==========================================================================
// Edge select codes
`define MCR_EDGE_NEG 2'h1
`define MCR_EDGE_POS 2'h2

// ==========================================================================
// Timing
`define MCR_CLK_PERIOD_NS 10
`define MCR_REVERSE_POLARITY_PIN_PERIOD_NS 1000000000

`endif

// File: rtl/mcr_pkg.sv
// Types shared by the metering configuration register block
package mcr_pkg;

  // ==========================================================================
  // Control bits as seen by the metering datapath
  typedef struct packed {
    logic active_noload_off;
    logic reactive_noload_off;
    logic apparent_noload_off;
    logic chan_a_active_linecycle_en;
    logic chan_b_active_linecycle_en;
    logic chan_a_reactive_linecycle_en;
    logic chan_b_reactive_linecycle_en;
    logic chan_a_apparent_linecycle_en;
    logic chan_b_apparent_linecycle_en;
    logic clear_on_read_en;
    logic chan_a_integrator_on;
    logic chan_b_integrator_on;
    logic highpass_on;
    logic powerfactor_basis;
    logic crossing_filter_off;
    logic checksum_on;
    logic interface_lock_on;
  } mcr_ctrl_s;

  // ==========================================================================
  // Whole state of the block
  typedef struct packed {
    logic [7:0] noload_disable;
    logic [7:0] line_cycle_mode;
    logic [15:0] main_config;
    logic [15:0] rd_data;
    logic rd_valid;
    logic soft_reset;
    logic pulse_one_d;
    logic pulse_two_d;
    logic reverse_held;
    logic [31:0] reverse_polarity_pin_cnt;
    logic reverse_polarity_pin;
    logic volt_sign_d;
    logic crossing_irq;
    logic current_crossing;
  } mcr_state_s;

endpackage : mcr_pkg

// File: tb/mcr_host_model.sv
// Host model driving the register port of the configuration bank
`include "mcr_consts.svh"

module mcr_host_model (
  input wire logic mclk_in, // Device clock
  output logic wr_en_out, // Write strobe
  output logic rd_en_out, // Read strobe
  output logic [`MCR_ADDR_W-1:0] addr_out, // Register address
  output logic [15:0] wr_data_out // Write data
);
  timeunit 1ns;
  timeprecision 1ps;

  initial begin
    wr_en_out = 1'b0;
    rd_en_out = 1'b0;
    addr_out = '0;
    wr_data_out = '0;
  end

  // ==========================================================================
  // Write; reserved config bits go out as zero unless raw is set
  task automatic write(input logic [9:0] a, input logic [15:0] d, input bit raw = 1'b0);
    @(posedge mclk_in);
    wr_en_out <= 1'b1;
    addr_out <= a;
    wr_data_out <= (raw || a != `MCR_OFS_CONFIG) ? d : (d & 16'hb9ff);
    @(posedge mclk_in);
    wr_en_out <= 1'b0;
    addr_out <= ~a;
    wr_data_out <= ~d;
  endtask : write

  // ==========================================================================
  // Read, optionally after some idle cycles
  task automatic read(input logic [9:0] a, input int gap = 0);
    repeat (gap) @(posedge mclk_in);
    @(posedge mclk_in);
    rd_en_out <= 1'b1;
    addr_out <= a;
    @(posedge mclk_in);
    rd_en_out <= 1'b0;
    addr_out <= ~a;
  endtask : read
endmodule : mcr_host_model

// File: tb/mcr_config_regs_tb.sv
// Self-checking bench for the metering configuration register bank
`include "mcr_consts.svh"

module mcr_config_regs_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import mcr_pkg::*;
  localparam int REVERSE_POLARITY_PIN_CYC = 16;
  logic mclk_in = 1'b0, rst_in = 1'b1, wr_en, rd_en, rd_valid, rev = 1'b0, p1 = 1'b0, p2 = 1'b0;
  logic vs = 1'b0, sa = 1'b0, sb = 1'b0, srst, pin, irq, cur;
  logic [9:0] addr;
  logic [15:0] wdata, rd_data;
  mcr_ctrl_s ctrl;
  int err_count = 0, total_checks = 0, cycles = 0;
  integer seed = 32'h524b331d;
  logic [15:0] exp_q[$];

  always #5 mclk_in = ~mclk_in;

  mcr_host_model host (.mclk_in(mclk_in), .wr_en_out(wr_en), .rd_en_out(rd_en), .addr_out(addr),
    .wr_data_out(wdata));

  mcr_config_regs #(.REVERSE_POLARITY_PIN_PERIOD_CYC(REVERSE_POLARITY_PIN_CYC)) DUT (.mclk_in(mclk_in), .rst_in(rst_in), .wr_en_in(wr_en),
    .rd_en_in(rd_en), .addr_in(addr), .wr_data_in(wdata), .rd_data_out(rd_data), .rd_valid_out(rd_valid),
    .reverse_polarity_in(rev), .pulse_out_one_in(p1), .pulse_out_two_in(p2), .voltage_sign_in(vs),
    .chan_a_sign_in(sa), .chan_b_sign_in(sb), .ctrl_out(ctrl), .soft_reset_out(srst),
    .reverse_polarity_pin_out(pin), .crossing_irq_out(irq), .current_crossing_out(cur));

  // ==========================================================================
  // Checking and reporting
  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("[FAIL] %s expected %h seen %h", name, exp, seen);
    end
  endtask : chk

  task automatic wrap_up();
    $display("checks %0d mismatches %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : wrap_up

  always @(posedge mclk_in) begin
    if (rd_valid === 1'b1) begin
      if (exp_q.size() == 0) chk("unexpected read", 1, 0);
      else chk("read data", rd_data, exp_q.pop_front());
    end
  end

  always @(posedge mclk_in) begin
    cycles++;
    if (cycles >= 20000) begin
      err_count++;
      wrap_up();
    end
  end

  // ==========================================================================
  // Helpers
  task automatic rd(input logic [9:0] a, input logic [15:0] e);
    exp_q.push_back(e);
    host.read(a, int'(e[0]));
  endtask : rd

  task automatic tick(input int n);
    repeat (n) @(posedge mclk_in);
  endtask : tick

  task automatic pulse(input bit two);
    @(posedge mclk_in);
    if (two) p2 <= 1'b1;
    else p1 <= 1'b1;
    @(posedge mclk_in);
    p1 <= 1'b0;
    p2 <= 1'b0;
  endtask : pulse

  // Counts cycles with the chosen output high: 0 irq, 1 pin, 2 soft reset
  task automatic count(input int sel, input int n, output int c);
    c = 0;
    repeat (n) begin
      @(posedge mclk_in);
      if ((sel == 0 ? irq : sel == 1 ? pin : srst) === 1'b1) c++;
    end
  endtask : count

  function automatic logic [16:0] exp_ctrl(input logic [7:0] nl, input logic [7:0] lc, input logic [15:0] cf);
    return {nl[0], nl[1], nl[2], lc[0], lc[1], lc[2], lc[3], lc[4], lc[5], lc[6], cf[0], cf[1], cf[2], cf[3],
      cf[6], cf[8], ~cf[15]};
  endfunction : exp_ctrl

  // ==========================================================================
  // Main sequence
  initial begin
    logic [15:0] d[3];
    int c;
    tick(6);
    rst_in <= 1'b0;
    rd(`MCR_OFS_NOLOAD, 16'h0000);
    rd(`MCR_OFS_LINECYC, 16'h0040);
    rd(`MCR_OFS_CONFIG, 16'h8004);
    chk("ctrl reset", ctrl, exp_ctrl(8'h00, 8'h40, 16'h8004));
    $display("test reset done");
    for (int i = 0; i < 8; i++) begin
      d[0] = 16'($random(seed));
      d[1] = 16'($random(seed));
      d[2] = 16'($random(seed)) & 16'hff7f;
      host.write(`MCR_OFS_NOLOAD, d[0]);
      host.write(`MCR_OFS_LINECYC, d[1]);
      host.write(`MCR_OFS_CONFIG, d[2], i[0]);
      host.write(10'h003, 16'hffff);
      rd(`MCR_OFS_NOLOAD, d[0] & 16'h0007);
      rd(`MCR_OFS_LINECYC, d[1] & 16'h007f);
      rd(`MCR_OFS_CONFIG, d[2] & 16'hb97f);
      rd(10'h003, 16'h0000);
      tick(2);
      chk("ctrl fields", ctrl, exp_ctrl(d[0][7:0], d[1][7:0], d[2]));
    end
    $display("test random access done");
    host.write(`MCR_OFS_NOLOAD, 16'h0007);
    host.write(`MCR_OFS_CONFIG, 16'h0189);
    count(2, 4, c);
    chk("soft reset pulses", c, 1);
    rd(`MCR_OFS_CONFIG, 16'h8004);
    rd(`MCR_OFS_NOLOAD, 16'h0000);
    $display("test soft reset done");
    for (int k = 0; k < 4; k++) begin
      host.write(`MCR_OFS_CONFIG, 16'h8004 | (16'(k) << 12));
      @(posedge mclk_in);
      vs <= 1'b1;
      count(0, 4, c);
      chk("crossing rise", c, k != 1);
      vs <= 1'b0;
      count(0, 4, c);
      chk("crossing fall", c, k != 2);
    end
    $display("test crossing edges done");
    sb <= 1'b1;
    host.write(`MCR_OFS_CONFIG, 16'h8804);
    tick(3);
    chk("current src b", cur, 1);
    host.write(`MCR_OFS_CONFIG, 16'h8004);
    tick(3);
    chk("current src a", cur, 0);
    $display("test current crossing done");
    rev <= 1'b1;
    pulse(1'b1);
    tick(4);
    chk("pin wrong source", pin, 0);
    pulse(1'b0);
    tick(4);
    chk("pin level", pin, 1);
    host.write(`MCR_OFS_CONFIG, 16'h8034);
    count(1, 2 * REVERSE_POLARITY_PIN_CYC, c);
    chk("pin pulse duty", c, REVERSE_POLARITY_PIN_CYC);
    rev <= 1'b0;
    pulse(1'b0);
    count(1, 2 * REVERSE_POLARITY_PIN_CYC, c);
    chk("pin ignores first", c, REVERSE_POLARITY_PIN_CYC);
    pulse(1'b1);
    tick(4);
    count(1, 2 * REVERSE_POLARITY_PIN_CYC, c);
    chk("pin low", c, 0);
    $display("test reverse polarity done");
    tick(4);
    chk("queue empty", exp_q.size(), 0);
    wrap_up();
  end
endmodule : mcr_config_regs_tb
